// ---- spc_pkg.sv ----
package spc_pkg;

   // Register map, byte addresses on the AXI4-Lite slave
   localparam int AXI_AW = 5;
   localparam logic [AXI_AW-1:0] REG_CTRL = 5'h00;
   localparam logic [AXI_AW-1:0] REG_STATUS = 5'h04;
   localparam logic [AXI_AW-1:0] REG_IRQ_STAT = 5'h08;
   localparam logic [AXI_AW-1:0] REG_IRQ_MASK = 5'h0C;

   // Control register fields
   localparam int CTL_RX_POL = 0;
   localparam int CTL_TX_POL = 1;
   localparam int CTL_BYPASS = 2;
   localparam int CTL_WIDTH10 = 3;
   localparam int CTL_HALF = 4;
   localparam int CTL_CTC_EN = 5;
   localparam int CTL_REALIGN = 6;
   localparam int CTL_SLIP = 7;
   localparam logic [7:0] CTRL_RST = 8'h28;
   localparam logic [7:0] CTRL_PULSE_MASK = 8'hC0;

   // Status register fields
   localparam int ST_LOCKED = 0;
   localparam int ST_RX_RD = 1;
   localparam int ST_TX_RD = 2;
   localparam int ST_SKIP_LSB = 8;

   // Interrupt status and mask fields
   localparam int IRQ_W = 4;
   localparam int IRQ_CODE = 0;
   localparam int IRQ_DISP = 1;
   localparam int IRQ_LOCK = 2;
   localparam int IRQ_SKIP = 3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Word lengths on the serial side
   localparam logic [3:0] LEN10 = 4'hA;
   localparam logic [3:0] LEN8 = 4'h8;

   // Line code constants
   localparam logic [6:0] COMMA_P = 7'h1F;
   localparam logic [6:0] COMMA_N = 7'h60;
   localparam logic [5:0] K6_NEG = 6'h0F;
   localparam logic [4:0] K28_X = 5'h1C;
   localparam logic [4:0] D7_X = 5'h07;
   localparam logic [2:0] Y3 = 3'h3;
   localparam logic [2:0] Y7 = 3'h7;
   localparam logic [3:0] A7_CODE = 4'h7;
   localparam logic [7:0] SKIP_BYTE = 8'h1C;
   localparam logic [7:0] IDLE_BYTE = 8'hBC;

   // 5b/6b and 3b/4b codes for negative running disparity, abcdei / fghj MSB first
   localparam logic [5:0] TAB6 [32] = '{
      6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
      6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [3:0] TAB4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

   function automatic logic rd_after(input logic [5:0] c, input int n, input logic rd);
      int ones;
      ones = $countones(c);
      if (2 * ones == n) return rd;
      return (2 * ones > n);
   endfunction

   function automatic logic [5:0] enc6(input logic [4:0] x, input logic rdp);
      logic [5:0] t;
      t = TAB6[x];
      if (rdp && (($countones(t) != 3) || (x == D7_X))) t = ~t;
      return t;
   endfunction

   function automatic logic [3:0] enc4(input logic [2:0] y, input logic rdp,
                                       input logic [4:0] x, input logic k);
      logic a7;
      logic [3:0] t;
      logic [3:0] p;
      a7 = (y == Y7) && (k || (!rdp && (x == 5'h11 || x == 5'h12 || x == 5'h14))
           || (rdp && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
      t = a7 ? A7_CODE : TAB4[y];
      p = (($countones(t) != 2) || (y == Y3)) ? ~t : t;
      if (k) return rdp ? p : ~p;
      return rdp ? p : t;
   endfunction

   // Returns {rd_out, code[9:0]}; only K28.y control symbols are produced
   function automatic logic [10:0] enc10(input logic [7:0] d, input logic k, input logic rd);
      logic [5:0] c6;
      logic [3:0] c4;
      logic m;
      c6 = k ? (rd ? ~K6_NEG : K6_NEG) : enc6(d[4:0], rd);
      m = rd_after(c6, 6, rd);
      c4 = enc4(d[7:5], m, d[4:0], k);
      return {rd_after({2'h0, c4}, 4, m), c6, c4};
   endfunction

   // Returns {rd_out, code_err, disp_err, k, byte[7:0]}
   function automatic logic [11:0] dec10(input logic [9:0] code, input logic rd);
      logic [5:0] c6;
      logic [3:0] c4;
      logic hit6, bad6, hit4, bad4, k, m, cerr, derr;
      logic [4:0] x;
      logic [2:0] y;
      c6 = code[9:4];
      c4 = code[3:0];
      hit6 = 1'b0;
      bad6 = 1'b0;
      hit4 = 1'b0;
      bad4 = 1'b0;
      x = 5'h00;
      y = 3'h0;
      k = (c6 == K6_NEG) || (c6 == ~K6_NEG);
      if (k) begin
         x = K28_X;
         hit6 = (c6 == (rd ? ~K6_NEG : K6_NEG));
         bad6 = !hit6;
      end else begin
         for (int i = 0; i < 32; i++) begin
            if (enc6(5'(i), rd) == c6) begin
               hit6 = 1'b1;
               x = 5'(i);
            end else if (enc6(5'(i), !rd) == c6) begin
               bad6 = 1'b1;
               x = 5'(i);
            end
         end
      end
      m = rd_after(c6, 6, rd);
      for (int j = 0; j < 8; j++) begin
         if (enc4(3'(j), m, x, k) == c4) begin
            hit4 = 1'b1;
            y = 3'(j);
         end else if (enc4(3'(j), !m, x, k) == c4) begin
            bad4 = 1'b1;
            y = 3'(j);
         end
      end
      cerr = !(hit6 || bad6) || !(hit4 || bad4);
      derr = !cerr && ((bad6 && !hit6) || (bad4 && !hit4));
      return {rd_after({2'h0, c4}, 4, m), cerr, derr, k, y, x};
   endfunction

endpackage

// ---- spc_aligner.sv ----
`timescale 1ns/1ps
module spc_aligner
   import spc_pkg::*;
#(
   parameter int W = 10
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Recovered bit stream
   input wire logic bit_in,
   // Control
   input wire logic len10,
   input wire logic comma_en,
   input wire logic realign,
   input wire logic slip,
   // Aligned words
   output logic [W-1:0] word_q,
   output logic word_valid_q,
   output logic locked_q,
   output logic lock_pulse_q
);

   logic [W-1:0] sh_q;
   logic [W-1:0] sh_d;
   logic [3:0] cnt_q;
   logic [3:0] last;
   logic comma_hit;
   logic capture;
   logic emit;

   assign sh_d = {sh_q[W-2:0], bit_in};
   assign last = len10 ? LEN10 - 4'h1 : LEN8 - 4'h1;
   assign comma_hit = comma_en && len10 &&
                      ((sh_d[W-1 -: 7] == COMMA_P) || (sh_d[W-1 -: 7] == COMMA_N));
   assign capture = comma_en && !locked_q && !realign && comma_hit;
   assign emit = (locked_q && (cnt_q == last) && !slip) || capture;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sh_q <= '0;
      end else begin
         sh_q <= sh_d;
      end
   end

   // Once locked, a later comma at another offset is ignored until realign
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         locked_q <= 1'b0;
         lock_pulse_q <= 1'b0;
      end else begin
         lock_pulse_q <= capture;
         if (!comma_en) begin
            locked_q <= 1'b1;
         end else if (realign) begin
            locked_q <= 1'b0;
         end else if (capture) begin
            locked_q <= 1'b1;
         end
      end
   end

   // Slip holds the count one bit, moving the boundary one bit later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 4'h0;
      end else if (capture || (emit && locked_q)) begin
         cnt_q <= 4'h0;
      end else if (!slip) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         word_q <= '0;
         word_valid_q <= 1'b0;
      end else begin
         word_valid_q <= emit;
         if (emit) begin
            word_q <= len10 ? sh_d : {{(W-8){1'b0}}, sh_d[7:0]};
         end
      end
   end

endmodule

// ---- spc_pcs_channel.sv ----
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Function
// - Receive serial stream deserialized into 8/10-bit words
// - Transmit words of 8/10 bits shifted out serially
// - Receive and transmit word clocks reach fabric
// - Receive order: polarity, align, decode, tolerance compensation
// - Receive words cross to fabric via down-sample stage
// - Transmit order: encode, polarity, then serializer
// - Bypass passes raw 8/10-bit words, skipping coding
// - Half rate presents two words as 16/20 bits
// - Bit slip shifts the receive word boundary
module spc_pcs_channel
   import spc_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Serial link, one bit per clock
   input wire logic rx_serial,
   output logic tx_serial,
   // Word clock enables toward fabric
   output logic rx_word_tick,
   output logic tx_word_tick,
   // Fabric receive side
   output logic [19:0] rx_fab_data,
   output logic [1:0] rx_fab_k,
   output logic [1:0] rx_fab_code_err,
   output logic [1:0] rx_fab_disp_err,
   output logic rx_fab_valid,
   input wire logic rx_slip_req,
   // Fabric transmit side
   input wire logic [19:0] tx_fab_data,
   input wire logic [1:0] tx_fab_k,
   input wire logic tx_fab_valid,
   output logic tx_fab_ready,
   // Interrupt
   output logic irq
);

   logic [7:0] ctrl_q;
   logic realign_q;
   logic slip_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [IRQ_W-1:0] irq_ev;
   logic [IRQ_W-1:0] irq_clr;
   logic [7:0] skip_cnt_q;

   logic bypass;
   logic half;
   logic len10;

   logic aw_got_q;
   logic w_got_q;
   logic [AXI_AW-1:0] awaddr_q;
   logic [7:0] wdata_q;
   logic wstrb0_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic do_write;
   logic rd_take;
   logic [AXI_AW-1:0] rd_word;
   logic [AXI_AW-1:0] wr_word;

   logic rx_meta_q;
   logic rx_sync_q;
   logic rx_bit;
   logic [9:0] al_word;
   logic al_valid;
   logic al_locked;
   logic al_lock_pulse;
   logic rx_rd_q;
   logic [11:0] dec;
   logic skip_drop;
   logic ln_valid;
   logic [9:0] ln_data;
   logic ln_k;
   logic ln_cerr;
   logic ln_derr;
   logic rx_ph_q;
   logic [9:0] lo_data_q;
   logic lo_k_q;
   logic lo_cerr_q;
   logic lo_derr_q;
   logic [19:0] rx_data_q;
   logic [1:0] rx_k_q;
   logic [1:0] rx_cerr_q;
   logic [1:0] rx_derr_q;
   logic rx_valid_q;

   logic [3:0] tx_cnt_q;
   logic [3:0] tx_len;
   logic tx_load;
   logic tx_ph_q;
   logic [9:0] hi_data_q;
   logic hi_k_q;
   logic hi_valid_q;
   logic [9:0] tx_word;
   logic tx_k;
   logic tx_have;
   logic [10:0] enc;
   logic [9:0] tx_code;
   logic [9:0] tx_sh_q;
   logic tx_rd_q;

   assign bypass = ctrl_q[CTL_BYPASS];
   assign half = ctrl_q[CTL_HALF];
   assign len10 = !bypass || ctrl_q[CTL_WIDTH10];

   // ---------------- AXI4-Lite slave ----------------
   assign s_axi_awready = !aw_got_q;
   assign s_axi_wready = !w_got_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign do_write = aw_got_q && w_got_q && !bvalid_q;
   assign rd_take = s_axi_arvalid && !rvalid_q;
   assign rd_word = {s_axi_araddr[AXI_AW-1:2], 2'h0};
   assign wr_word = {awaddr_q[AXI_AW-1:2], 2'h0};

   // Address and data are latched separately, so either may arrive first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 8'h00;
         wstrb0_q <= 1'b0;
      end else begin
         if (s_axi_awvalid && !aw_got_q) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (do_write) begin
            aw_got_q <= 1'b0;
         end
         if (s_axi_wvalid && !w_got_q) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
         end else if (do_write) begin
            w_got_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q <= (wr_word == REG_CTRL || wr_word == REG_STATUS ||
                     wr_word == REG_IRQ_STAT || wr_word == REG_IRQ_MASK) ?
                    RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Realign and slip are write-one pulses and never stored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RST;
         irq_mask_q <= '0;
         realign_q <= 1'b0;
         slip_q <= 1'b0;
      end else begin
         realign_q <= 1'b0;
         slip_q <= rx_slip_req;
         if (do_write && wstrb0_q) begin
            if (wr_word == REG_CTRL) begin
               ctrl_q <= wdata_q & ~CTRL_PULSE_MASK;
               realign_q <= wdata_q[CTL_REALIGN];
               slip_q <= wdata_q[CTL_SLIP] || rx_slip_req;
            end
            if (wr_word == REG_IRQ_MASK) begin
               irq_mask_q <= wdata_q[IRQ_W-1:0];
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else if (rd_take) begin
         rvalid_q <= 1'b1;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0000_0000;
         case (rd_word)
            REG_CTRL: rdata_q[7:0] <= ctrl_q;
            REG_STATUS: begin
               rdata_q[ST_LOCKED] <= al_locked;
               rdata_q[ST_RX_RD] <= rx_rd_q;
               rdata_q[ST_TX_RD] <= tx_rd_q;
               rdata_q[ST_SKIP_LSB +: 8] <= skip_cnt_q;
            end
            REG_IRQ_STAT: rdata_q[IRQ_W-1:0] <= irq_stat_q;
            REG_IRQ_MASK: rdata_q[IRQ_W-1:0] <= irq_mask_q;
            default: rresp_q <= RESP_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ---------------- Interrupts ----------------
   assign irq_ev[IRQ_CODE] = al_valid && !bypass && ln_cerr;
   assign irq_ev[IRQ_DISP] = al_valid && !bypass && ln_derr;
   assign irq_ev[IRQ_LOCK] = al_lock_pulse;
   assign irq_ev[IRQ_SKIP] = skip_drop;
   assign irq_clr = (rd_take && rd_word == REG_IRQ_STAT) ? irq_stat_q : '0;
   assign irq = |(irq_stat_q & irq_mask_q);

   // A new event in the clearing cycle survives the read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_q <= '0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
      end
   end

   // ---------------- Receive path ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_meta_q <= 1'b0;
         rx_sync_q <= 1'b0;
      end else begin
         rx_meta_q <= rx_serial;
         rx_sync_q <= rx_meta_q;
      end
   end

   assign rx_bit = rx_sync_q ^ ctrl_q[CTL_RX_POL];

   spc_aligner #(
      .W(10)
   ) u_aligner (
      .aclk(aclk),
      .aresetn(aresetn),
      .bit_in(rx_bit),
      .len10(len10),
      .comma_en(!bypass),
      .realign(realign_q),
      .slip(slip_q),
      .word_q(al_word),
      .word_valid_q(al_valid),
      .locked_q(al_locked),
      .lock_pulse_q(al_lock_pulse)
   );

   assign dec = dec10(al_word, rx_rd_q);
   assign rx_word_tick = al_valid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_rd_q <= 1'b0;
      end else if (al_valid && !bypass) begin
         rx_rd_q <= dec[11];
      end
   end

   assign ln_data = bypass ? al_word : {2'h0, dec[7:0]};
   assign ln_k = !bypass && dec[8];
   assign ln_cerr = !bypass && dec[10];
   assign ln_derr = !bypass && dec[9];
   // Only deletion of skip symbols is done; the link never sends faster than aclk
   assign skip_drop = al_valid && !bypass && ctrl_q[CTL_CTC_EN] && ln_k &&
                      !ln_cerr && (dec[7:0] == SKIP_BYTE);
   assign ln_valid = al_valid && !skip_drop;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         skip_cnt_q <= 8'h00;
      end else if (skip_drop) begin
         skip_cnt_q <= skip_cnt_q + 8'h01;
      end
   end

   // Down-sample stage: in half rate the first word waits for its partner
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_ph_q <= 1'b0;
         lo_data_q <= 10'h000;
         lo_k_q <= 1'b0;
         lo_cerr_q <= 1'b0;
         lo_derr_q <= 1'b0;
      end else if (!half) begin
         rx_ph_q <= 1'b0;
      end else if (ln_valid) begin
         rx_ph_q <= !rx_ph_q;
         if (!rx_ph_q) begin
            lo_data_q <= ln_data;
            lo_k_q <= ln_k;
            lo_cerr_q <= ln_cerr;
            lo_derr_q <= ln_derr;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_data_q <= 20'h00000;
         rx_k_q <= 2'h0;
         rx_cerr_q <= 2'h0;
         rx_derr_q <= 2'h0;
         rx_valid_q <= 1'b0;
      end else begin
         rx_valid_q <= ln_valid && (!half || rx_ph_q);
         if (ln_valid && half && rx_ph_q) begin
            rx_data_q <= {ln_data, lo_data_q};
            rx_k_q <= {ln_k, lo_k_q};
            rx_cerr_q <= {ln_cerr, lo_cerr_q};
            rx_derr_q <= {ln_derr, lo_derr_q};
         end else if (ln_valid && !half) begin
            rx_data_q <= {10'h000, ln_data};
            rx_k_q <= {1'b0, ln_k};
            rx_cerr_q <= {1'b0, ln_cerr};
            rx_derr_q <= {1'b0, ln_derr};
         end
      end
   end

   assign rx_fab_data = rx_data_q;
   assign rx_fab_k = rx_k_q;
   assign rx_fab_code_err = rx_cerr_q;
   assign rx_fab_disp_err = rx_derr_q;
   assign rx_fab_valid = rx_valid_q;

   // ---------------- Transmit path ----------------
   assign tx_len = len10 ? LEN10 : LEN8;
   assign tx_load = (tx_cnt_q == 4'h0);
   assign tx_word_tick = tx_load;
   assign tx_fab_ready = tx_load && (!half || !tx_ph_q);
   assign tx_have = half && tx_ph_q ? hi_valid_q : tx_fab_valid;
   assign tx_word = half && tx_ph_q ? hi_data_q : tx_fab_data[9:0];
   assign tx_k = half && tx_ph_q ? hi_k_q : tx_fab_k[0];

   // Outside bypass, idle commas fill gaps when fabric offers nothing; bypass sends zero words
   assign enc = tx_have ? enc10(tx_word[7:0], tx_k, tx_rd_q) :
                          enc10(IDLE_BYTE, 1'b1, tx_rd_q);
   always_comb begin
      if (!bypass) begin
         tx_code = enc[9:0];
      end else if (len10) begin
         tx_code = tx_have ? tx_word : 10'h000;
      end else begin
         tx_code = {tx_have ? tx_word[7:0] : 8'h00, 2'h0};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_ph_q <= 1'b0;
         hi_data_q <= 10'h000;
         hi_k_q <= 1'b0;
         hi_valid_q <= 1'b0;
      end else if (!half) begin
         tx_ph_q <= 1'b0;
      end else if (tx_load) begin
         tx_ph_q <= !tx_ph_q;
         if (!tx_ph_q) begin
            hi_data_q <= tx_fab_data[19:10];
            hi_k_q <= tx_fab_k[1];
            hi_valid_q <= tx_fab_valid;
         end
      end
   end

   // Polarity is applied after coding, on the word handed to the shifter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_cnt_q <= 4'h0;
         tx_sh_q <= 10'h000;
         tx_rd_q <= 1'b0;
      end else if (tx_load) begin
         tx_cnt_q <= tx_len - 4'h1;
         tx_sh_q <= tx_code ^ {10{ctrl_q[CTL_TX_POL]}};
         if (!bypass) begin
            tx_rd_q <= enc[10];
         end
      end else begin
         tx_cnt_q <= tx_cnt_q - 4'h1;
         tx_sh_q <= {tx_sh_q[8:0], 1'b0};
      end
   end

   assign tx_serial = tx_sh_q[9];

endmodule

// ---- spc_pcs_channel_sva.sv ----
`timescale 1ns/1ps
module spc_pcs_channel_sva (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus and stream
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_fab_valid,
   input wire logic [19:0] rx_fab_data,
   input wire logic tx_fab_ready,
   input wire logic rx_word_tick,
   input wire logic tx_word_tick
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wr_answer_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("bvalid late");
   b_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bvalid dropped");
   rd_answer_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("rvalid late");
   rd_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rdata dropped");
   rx_pulse_a: assert property (
      rx_fab_valid |=> !rx_fab_valid) else $error("rx valid too long");
   rx_stand_a: assert property (
      !rx_fab_valid |-> $stable(rx_fab_data)) else $error("rx data moved");
   tx_gap_a: assert property (
      tx_fab_ready |=> !tx_fab_ready [*7]) else $error("tx word too soon");
   tx_tick_a: assert property (
      tx_fab_ready |-> tx_word_tick) else $error("tx tick missing");
   rx_tick_a: assert property (
      rx_fab_valid |-> $past(rx_word_tick)) else $error("rx tick missing");
endmodule
bind spc_pcs_channel spc_pcs_channel_sva chk (.*);

// ---- spc_link_model.sv ----
`timescale 1ns/1ps
module spc_link_model (
   input wire logic aclk,
   input wire logic invert,
   input wire logic tx_serial,
   output logic rx_serial = 1'b0
);
   // Far end looped back; invert stands for a swapped wire pair
   always @(posedge aclk) rx_serial <= tx_serial ^ invert;
endmodule

// ---- spc_pcs_channel_tb_top.sv ----
`timescale 1ns/1ps
module spc_pcs_channel_tb_top;
   import spc_pkg::*;
   logic aclk = 0, aresetn = 0, inv = 0, chk_on = 0, half = 0, byp = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, rx_slip_req = 0, tx_fab_valid = 0;
   logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'h71E6FA04;
   logic [31:0] pol[2] = '{32'h2A, 32'h29};
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, rx_fab_k, rx_fab_code_err, rx_fab_disp_err;
   logic [1:0] tx_fab_k = '0;
   logic [19:0] rx_fab_data, tx_fab_data = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic rx_serial, tx_serial, rx_word_tick, tx_word_tick, rx_fab_valid, tx_fab_ready, irq;
   logic [65:0] e;
   logic [12:0] g;
   logic [65:0] rq[$];
   logic [10:0] xq[$];
   int err_count = 0;
   int samples_checked = 0;

   always #5 aclk = ~aclk;
   spc_pcs_channel uut (.*);
   spc_link_model far (.aclk, .invert(inv), .tx_serial, .rx_serial);

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      fork
         begin
            do @(posedge aclk); while (!s_axi_awready);
            s_axi_awvalid <= 0;
         end
         begin
            do @(posedge aclk); while (!s_axi_wready);
            s_axi_wvalid <= 0;
         end
      join
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 0;
   endtask

   // Read data is masked so bits of unknown history are not judged
   task automatic rd(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [1:0] r);
      rq.push_back({m, r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 0;
   endtask

   // Valid stays up between words; burst lowers it once at the end
   task automatic tx(input logic [19:0] d, input logic [1:0] k, input int n);
      tx_fab_data <= d;
      tx_fab_k <= k;
      tx_fab_valid <= 1;
      if (n > 0) xq.push_back({k[0], d[9:0]});
      if (n > 1) xq.push_back({k[1], d[19:10]});
      do @(posedge aclk); while (!tx_fab_ready);
   endtask

   task automatic burst(input int n, input int l);
      for (int i = 0; i < n; i++) begin
         seed = xs(seed);
         tx({2'h0, seed[17:10], 1'b0, byp, seed[7:0]}, 2'h0, l);
      end
      tx_fab_valid <= 0;
      repeat (80) @(posedge aclk);
   endtask

   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         e = rq.pop_front();
         chk({s_axi_rresp, s_axi_rdata & e[65:34]}, e[33:0], "rd");
      end
      if (rx_fab_valid && chk_on)
         for (int l = 0; l <= int'(half); l++)
            // Bypass fills gaps with zero words; its data words carry bit 8 set
            if (!(rx_fab_k[l] && rx_fab_data[10*l+:8] == IDLE_BYTE) &&
                !(byp && rx_fab_data[10*l+:10] == 10'h000)) begin
               g = {rx_fab_code_err[l], rx_fab_disp_err[l], rx_fab_k[l], rx_fab_data[10*l+:10]};
               chk(34'(g), 34'(xq.pop_front()), "rx");
            end
   end

   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      conclude();
   end

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rd(REG_CTRL, 32'h28, '1, RESP_OKAY);
      rd(REG_IRQ_MASK, 32'h0, '1, RESP_OKAY);
      rd(5'h10, 32'h0, '1, RESP_SLVERR);
      repeat (100) @(posedge aclk);
      rd(REG_STATUS, 32'h1, 32'h1, RESP_OKAY);
      wr(REG_IRQ_MASK, 32'h4);
      @(posedge aclk);
      chk(34'(irq), 34'h1, "irq");
      rd(REG_IRQ_STAT, 32'h4, 32'h4, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(34'(irq), 34'h0, "irq");
      $display("lock test done");
      chk_on = 1;
      burst(20, 1);
      tx({12'h0, SKIP_BYTE}, 2'h1, 0);
      burst(4, 1);
      rd(REG_STATUS, 32'h101, 32'hFF01, RESP_OKAY);
      rd(REG_IRQ_STAT, 32'h8, 32'h8, RESP_OKAY);
      chk(34'(irq), 34'h0, "irq");
      $display("data test done");
      foreach (pol[i]) begin
         chk_on = 0;
         inv <= 1;
         wr(REG_CTRL, pol[i]);
         repeat (100) @(posedge aclk);
         chk_on = 1;
         burst(16, 1);
      end
      $display("polarity test done");
      chk_on = 0;
      inv <= 0;
      wr(REG_CTRL, 32'h28);
      rx_slip_req <= 1;
      @(posedge aclk);
      rx_slip_req <= 0;
      repeat (50) @(posedge aclk);
      wr(REG_CTRL, 32'h68);
      repeat (100) @(posedge aclk);
      rd(REG_IRQ_STAT, 32'h4, 32'h4, RESP_OKAY);
      chk_on = 1;
      burst(12, 1);
      $display("realign test done");
      chk_on = 0;
      wr(REG_CTRL, 32'h2C);
      byp = 1;
      repeat (100) @(posedge aclk);
      chk_on = 1;
      burst(12, 1);
      $display("bypass test done");
      chk_on = 0;
      wr(REG_CTRL, 32'h38);
      half = 1;
      byp = 0;
      repeat (100) @(posedge aclk);
      chk_on = 1;
      burst(12, 2);
      chk(34'(xq.size()), 34'h0, "left");
      $display("half rate test done");
      conclude();
   end
endmodule
